// ---- shared/icscb_consts.svh ----
// Register offsets, field positions, reset values and timing figures of the clock source block
`ifndef ICSCB_CONSTS_SVH
`define ICSCB_CONSTS_SVH

`define ICSCB_OFS_CTRL1   4'h0
`define ICSCB_OFS_CTRL2   4'h4
`define ICSCB_OFS_TRIM    4'h8
`define ICSCB_OFS_STAT    4'hC

`define ICSCB_SEL_BIT     6
`define ICSCB_KEEP_BIT    0
`define ICSCB_DIV_HI      7
`define ICSCB_DIV_LO      6
`define ICSCB_LP_BIT      3
`define ICSCB_FINE_BIT    0
`define ICSCB_STAT_BIT    2

`define ICSCB_DIV_RST     2'h1
`define ICSCB_LOOP_MULT   10'h200

`define ICSCB_CLK_MHZ     40
`define ICSCB_T_IR_WU_NS  60000
`define ICSCB_T_FLL_WU_NS 1000

`define ICSCB_RESP_OK     2'h0
`define ICSCB_RESP_ERR    2'h2

`endif

// ---- shared/icscb_pkg.sv ----
// Types shared by the clock source block files
package icscb_pkg;

  typedef enum logic [4:0] {
    icscb_eng  = 5'h01,
    icscb_byp  = 5'h02,
    icscb_blp  = 5'h04,
    icscb_stop = 5'h08,
    icscb_wake = 5'h10
  } icscb_mode_t;

  typedef struct packed {
    logic sys;
    logic bus;
    logic ref_clk;
  } icscb_clk_t;

  typedef struct packed {
    icscb_mode_t mode;
    icscb_mode_t prev;
    logic        sel;
    logic        keep;
    logic [1:0]  div;
    logic        lp;
    logic [15:0] cnt;
    logic        ack;
    logic [7:0]  rdata;
    logic [1:0]  resp;
  } icscb_state_t;

endpackage

// ---- logic/icscb_tick_div.sv ----
// Power-of-two divider of a clock-edge enable stream
`timescale 1ns/10ps
module icscb_tick_div #(
  parameter int W = 2
) (
  input  logic         clk_i,
  input  logic         arst_n_i,
  input  logic         tick_i,
  input  logic [W-1:0] code_i,
  output logic         tick_o
);
  localparam int CW = (1 << W) - 1;

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] mask;

  // Mask is taken from the live code, so a new ratio applies on the next edge
  always_comb begin
    mask     = ~({CW{1'b1}} << code_i);
    next_cnt = tick_i ? cnt + CW'(1) : cnt;
  end

  assign tick_o = tick_i & ((cnt & mask) == '0);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// ---- logic/icscb_clk_switch.sv ----
// Glitch-free selection between the loop and reference edge streams
`timescale 1ns/10ps
module icscb_clk_switch (
  input  logic clk_i,
  input  logic arst_n_i,
  input  logic loop_tick_i,
  input  logic ref_tick_i,
  input  logic sel_i,
  output logic tick_o,
  output logic cur_o
);
  logic cur;
  logic next_cur;
  logic new_tick;

  // Output is muted while a change is pending, so no partial period escapes
  always_comb begin
    new_tick = sel_i ? ref_tick_i : loop_tick_i;
    next_cur = cur;
    if (sel_i != cur && new_tick) begin
      next_cur = sel_i;
    end
  end

  assign tick_o = (sel_i == cur) & (cur ? ref_tick_i : loop_tick_i);
  assign cur_o  = cur;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

// ---- logic/icscb_top.sv ----
// Clock source control: mode machine, register slave, source switch and bus divider
`timescale 1ns/10ps
`include "icscb_consts.svh"
module icscb_top #(
  parameter int T_IR_WU_NS  = `ICSCB_T_IR_WU_NS,
  parameter int T_FLL_WU_NS = `ICSCB_T_FLL_WU_NS
) (
  input  logic                   clk_i,
  input  logic                   arst_n_i,
  input  logic [3:0]             avs_address_i,
  input  logic                   avs_read_i,
  input  logic                   avs_write_i,
  input  logic [3:0]             avs_byteenable_i,
  input  logic [31:0]            avs_writedata_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic [1:0]             avs_response_o,
  input  logic                   stop_i,
  input  logic                   wake_i,
  input  logic                   loop_tick_i,
  input  logic                   ref_tick_i,
  output icscb_pkg::icscb_clk_t  clk_o,
  output logic                   loop_enable_o,
  output logic                   ref_enable_o,
  output logic [8:0]             trim_o,
  output logic [9:0]             loop_factor_o,
  output icscb_pkg::icscb_mode_t mode_o,
  output logic                   source_status_o
);
  localparam int IR_RAW  = (T_IR_WU_NS * `ICSCB_CLK_MHZ + 999) / 1000;
  localparam int FLL_RAW = (T_FLL_WU_NS * `ICSCB_CLK_MHZ + 999) / 1000;
  localparam int IR_CYC  = (IR_RAW < 1) ? 1 : IR_RAW;
  localparam int FLL_CYC = (FLL_RAW < 1) ? 1 : FLL_RAW;

  icscb_pkg::icscb_state_t st;
  icscb_pkg::icscb_state_t next_st;
  icscb_pkg::icscb_mode_t  run_mode;

  logic [7:0]  coarse;
  logic        fine;
  logic [7:0]  rd_val;
  logic        hit;
  logic        acc;
  logic        wr_go;
  logic        wr_ctrl1;
  logic        wr_ctrl2;
  logic        wr_trim;
  logic        wr_stat;
  logic        run;
  logic [15:0] wake_dly;
  logic        loop_tick_g;
  logic        ref_tick_g;
  logic        sel_tick;
  logic        sys_tick;
  logic        bus_tick;
  logic        src_status;

  // Bus decode; one wait state on every access
  assign acc      = avs_read_i | avs_write_i;
  assign hit      = (avs_address_i == `ICSCB_OFS_CTRL1) | (avs_address_i == `ICSCB_OFS_CTRL2) |
                    (avs_address_i == `ICSCB_OFS_TRIM) | (avs_address_i == `ICSCB_OFS_STAT);
  assign wr_go    = avs_write_i & st.ack & avs_byteenable_i[0];
  assign wr_ctrl1 = wr_go & (avs_address_i == `ICSCB_OFS_CTRL1);
  assign wr_ctrl2 = wr_go & (avs_address_i == `ICSCB_OFS_CTRL2);
  assign wr_trim  = wr_go & (avs_address_i == `ICSCB_OFS_TRIM);
  assign wr_stat  = wr_go & (avs_address_i == `ICSCB_OFS_STAT);

  assign avs_waitrequest_o = acc & ~st.ack;
  assign avs_readdata_o    = {24'h000000, st.rdata};
  assign avs_response_o    = st.resp;

  always_comb begin
    rd_val = 8'h00;
    if (avs_address_i == `ICSCB_OFS_CTRL1) begin
      rd_val[`ICSCB_SEL_BIT]  = st.sel;
      rd_val[`ICSCB_KEEP_BIT] = st.keep;
    end else if (avs_address_i == `ICSCB_OFS_CTRL2) begin
      rd_val[`ICSCB_DIV_HI:`ICSCB_DIV_LO] = st.div;
      rd_val[`ICSCB_LP_BIT] = st.lp;
    end else if (avs_address_i == `ICSCB_OFS_TRIM) begin
      rd_val = coarse;
    end else if (avs_address_i == `ICSCB_OFS_STAT) begin
      rd_val[`ICSCB_STAT_BIT] = src_status;
      rd_val[`ICSCB_FINE_BIT] = fine;
    end
  end

  // Run mode follows the select and low-power bits
  always_comb begin
    if (!st.sel) begin
      run_mode = icscb_pkg::icscb_eng;
    end else if (st.lp) begin
      run_mode = icscb_pkg::icscb_blp;
    end else begin
      run_mode = icscb_pkg::icscb_byp;
    end
  end

  // Wake delay: reference start-up if it was off, else loop recovery into engaged mode, else none
  always_comb begin
    if (!st.keep) begin
      wake_dly = 16'(IR_CYC);
    end else if (st.prev == icscb_pkg::icscb_eng) begin
      wake_dly = 16'(FLL_CYC);
    end else begin
      wake_dly = 16'h0000;
    end
  end

  always_comb begin
    next_st     = st;
    next_st.ack = acc & ~st.ack;
    if (acc & ~st.ack) begin
      next_st.rdata = avs_read_i ? rd_val : 8'h00;
      next_st.resp  = hit ? `ICSCB_RESP_OK : `ICSCB_RESP_ERR;
    end
    if (wr_ctrl1) begin
      next_st.sel  = avs_writedata_i[`ICSCB_SEL_BIT];
      next_st.keep = avs_writedata_i[`ICSCB_KEEP_BIT];
    end
    if (wr_ctrl2) begin
      next_st.div = avs_writedata_i[`ICSCB_DIV_HI:`ICSCB_DIV_LO];
      next_st.lp  = avs_writedata_i[`ICSCB_LP_BIT];
    end
    unique case (st.mode)
      icscb_pkg::icscb_eng,
      icscb_pkg::icscb_byp,
      icscb_pkg::icscb_blp: begin
        if (stop_i) begin
          next_st.prev = st.mode;
          next_st.mode = icscb_pkg::icscb_stop;
        end else begin
          next_st.mode = run_mode;
        end
      end
      icscb_pkg::icscb_stop: begin
        if (wake_i) begin
          if (wake_dly == 16'h0000) begin
            next_st.mode = st.prev;
          end else begin
            next_st.mode = icscb_pkg::icscb_wake;
            next_st.cnt  = wake_dly;
          end
        end
      end
      icscb_pkg::icscb_wake: begin
        if (st.cnt == 16'h0001) begin
          next_st.mode = st.prev;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st       <= '0;
      st.mode  <= icscb_pkg::icscb_eng;
      st.prev  <= icscb_pkg::icscb_eng;
      st.div   <= `ICSCB_DIV_RST;
    end else begin
      st <= next_st;
    end
  end

  // Trim bits carry no reset so that calibration survives every reset source
  always_ff @(posedge clk_i) begin
    if (wr_trim) begin
      coarse <= avs_writedata_i[7:0];
    end
    if (wr_stat) begin
      fine <= avs_writedata_i[`ICSCB_FINE_BIT];
    end
  end

  assign trim_o        = {coarse, fine};
  assign loop_factor_o = `ICSCB_LOOP_MULT;

  // Source enables and gating
  assign run = (st.mode == icscb_pkg::icscb_eng) | (st.mode == icscb_pkg::icscb_byp) |
               (st.mode == icscb_pkg::icscb_blp);

  assign loop_enable_o = (st.mode == icscb_pkg::icscb_eng) |
                         (st.mode == icscb_pkg::icscb_byp) |
                         ((st.mode == icscb_pkg::icscb_wake) &
                          (st.prev != icscb_pkg::icscb_blp));
  assign ref_enable_o  = (st.mode != icscb_pkg::icscb_stop) | st.keep;
  assign mode_o        = st.mode;

  assign loop_tick_g = loop_tick_i & loop_enable_o;
  assign ref_tick_g  = ref_tick_i & ref_enable_o;

  icscb_clk_switch u_switch (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .loop_tick_i (loop_tick_g),
    .ref_tick_i  (ref_tick_g),
    .sel_i       (st.sel),
    .tick_o      (sel_tick),
    .cur_o       (src_status)
  );

  icscb_tick_div #(
    .W (2)
  ) u_bus_div (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick_i   (sel_tick & run),
    .code_i   (st.div),
    .tick_o   (sys_tick)
  );

  icscb_tick_div #(
    .W (1)
  ) u_half (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick_i   (sys_tick),
    .code_i   (1'b1),
    .tick_o   (bus_tick)
  );

  assign clk_o.sys       = sys_tick;
  assign clk_o.bus       = bus_tick;
  assign clk_o.ref_clk   = ref_tick_g;
  assign source_status_o = src_status;

  // Checks beside the logic

  a_status_follow: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (src_status != $past(src_status)) |-> (src_status == $past(st.sel))
  ) else $error("status changed away from the selected source");

  a_switch_quiet: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st.sel != src_status) |-> !clk_o.sys
  ) else $error("system clock pulsed during a source change");

  a_stop_gated: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st.mode == icscb_pkg::icscb_stop) |-> (!clk_o.sys && !loop_enable_o)
  ) else $error("clock or loop active in stop");

  a_stop_ref_keep: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st.mode == icscb_pkg::icscb_stop) |-> (ref_enable_o == st.keep)
  ) else $error("reference enable in stop disagrees with keep bit");

  a_lp_loop_off: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (run && !stop_i && st.sel && st.lp)
      |=> (st.mode == icscb_pkg::icscb_blp && !loop_enable_o)
  ) else $error("loop running in low-power bypass");

  a_byp_loop_on: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (run && !stop_i && st.sel && !st.lp)
      |=> (st.mode == icscb_pkg::icscb_byp && loop_enable_o)
  ) else $error("loop stopped in plain bypass");

  a_sel_zero_eng: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_ctrl1 && run && !stop_i && !avs_writedata_i[`ICSCB_SEL_BIT])
      |=> !st.sel ##1 (st.mode == icscb_pkg::icscb_eng ||
                       st.mode == icscb_pkg::icscb_stop)
  ) else $error("select written zero did not give engaged mode");

  a_wake_ir_delay: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st.mode == icscb_pkg::icscb_stop && wake_i && !st.keep)
      |=> (st.mode == icscb_pkg::icscb_wake && st.cnt == 16'(IR_CYC))
  ) else $error("reference wake delay not loaded");

  a_wake_resume: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st.mode == icscb_pkg::icscb_wake && st.cnt == 16'h0001)
      |=> (st.mode == $past(st.prev))
  ) else $error("did not resume the mode held before stop");

  a_div_immediate: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_ctrl2 |=> (st.div == $past(avs_writedata_i[7:6]))
  ) else $error("divider write not applied at once");

  a_bus_half: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    clk_o.bus |-> clk_o.sys
  ) else $error("bus edge without a system edge");

  a_one_wait: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (acc && avs_waitrequest_o) |=> !avs_waitrequest_o
  ) else $error("access held more than one wait state");

  a_sys_source: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    clk_o.sys |-> (src_status ? ref_tick_g : loop_tick_g)
  ) else $error("system edge not taken from the source in use");

  a_ref_stop_quiet: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st.mode == icscb_pkg::icscb_stop && !st.keep) |-> !clk_o.ref_clk
  ) else $error("reference clock running in stop without keep");

  a_wake_loop_delay: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st.mode == icscb_pkg::icscb_stop && wake_i && st.keep &&
     st.prev == icscb_pkg::icscb_eng)
      |=> (st.mode == icscb_pkg::icscb_wake && st.cnt == 16'(FLL_CYC))
  ) else $error("loop recovery delay not loaded");

  a_wake_direct: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (st.mode == icscb_pkg::icscb_stop && wake_i && st.keep &&
     st.prev != icscb_pkg::icscb_eng)
      |=> (st.mode == $past(st.prev))
  ) else $error("did not return at once to the mode held before stop");

endmodule

// ---- tb/test_internal_clock_source_control.sv ----
// Self-checking bench for the clock source control block
`timescale 1ns/10ps
`include "icscb_consts.svh"
module test_internal_clock_source_control;
  localparam int T_IR    = 400;
  localparam int T_FLL   = 200;
  localparam int IR_CYC  = T_IR * `ICSCB_CLK_MHZ / 1000;
  localparam int FLL_CYC = T_FLL * `ICSCB_CLK_MHZ / 1000;
  logic                   clk_i;
  logic                   arst_n_i;
  logic [3:0]             avs_address_i;
  logic                   avs_read_i;
  logic                   avs_write_i;
  logic [3:0]             avs_byteenable_i;
  logic [31:0]            avs_writedata_i;
  logic [31:0]            avs_readdata_o;
  logic                   avs_waitrequest_o;
  logic [1:0]             avs_response_o;
  logic                   stop_i;
  logic                   wake_i;
  logic                   loop_tick_i = 1'b0;
  logic                   ref_tick_i = 1'b0;
  icscb_pkg::icscb_clk_t  clk_o;
  logic                   loop_enable_o;
  logic                   ref_enable_o;
  logic [8:0]             trim_o;
  logic [9:0]             loop_factor_o;
  icscb_pkg::icscb_mode_t mode_o;
  logic                   source_status_o;
  logic [33:0]            exp_q [$];
  logic [33:0]            sb_exp;
  logic [7:0]             coarse;
  logic                   cur_sel = 1'b0;
  int                     err_count = 0;
  int                     checks_done = 0;
  int                     sys_cnt = 0;
  int                     bus_cnt = 0;
  int                     src_cnt = 0;
  int                     wake_cnt = 0;
  int                     ref_cnt = 0;
  int                     seed_v;

  icscb_top #(.T_IR_WU_NS(T_IR), .T_FLL_WU_NS(T_FLL)) i_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .stop_i(stop_i), .wake_i(wake_i), .loop_tick_i(loop_tick_i), .ref_tick_i(ref_tick_i),
    .clk_o(clk_o), .loop_enable_o(loop_enable_o), .ref_enable_o(ref_enable_o),
    .trim_o(trim_o), .loop_factor_o(loop_factor_o), .mode_o(mode_o),
    .source_status_o(source_status_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task results;
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Oscillators only pulse while enabled, at uneven random rates
  always @(posedge clk_i) begin
    loop_tick_i <= (loop_enable_o === 1'b1) && ($urandom_range(1, 0) == 0);
    ref_tick_i  <= (ref_enable_o === 1'b1) && ($urandom_range(2, 0) == 0);
  end

  always @(posedge clk_i) begin
    if (clk_o.sys === 1'b1) sys_cnt++;
    if (clk_o.bus === 1'b1) bus_cnt++;
    if ((cur_sel ? ref_tick_i : loop_tick_i) === 1'b1) src_cnt++;
    if (mode_o === icscb_pkg::icscb_wake) wake_cnt++;
    if (clk_o.ref_clk === 1'b1) ref_cnt++;
  end

  // Read results are compared in the cycle the slave releases waitrequest
  always @(posedge clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      sb_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
      check({avs_response_o, avs_readdata_o}, sb_exp);
    end
  end

  task wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      results();
    end
  endtask

  task bus_rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 24'h0, d});
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    wait_ack();
    avs_read_i <= 1'b0;
  endtask

  task bus_wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_byteenable_i <= be;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= 1'b1;
    wait_ack();
    avs_write_i <= 1'b0;
  endtask

  task wait_mode(input icscb_pkg::icscb_mode_t m);
    int n;
    n = 0;
    while (mode_o !== m && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    check(mode_o, m);
    if (mode_o !== m) results();
  endtask

  task measure(input int d);
    int s0, b0, t0, k;
    s0 = sys_cnt;
    b0 = bus_cnt;
    t0 = src_cnt;
    k = 1 << d;
    repeat (400) @(posedge clk_i);
    s0 = sys_cnt - s0;
    b0 = bus_cnt - b0;
    t0 = src_cnt - t0;
    check((s0 * k <= t0 + k) && (t0 <= s0 * k + k), 1'b1);
    check((b0 * 2 <= s0 + 2) && (s0 <= b0 * 2 + 2), 1'b1);
  endtask

  task stop_run(input logic k, input icscb_pkg::icscb_mode_t pm, input int exp_w);
    int s0, w0, r0;
    bus_wr(`ICSCB_OFS_CTRL1, {1'b0, cur_sel, 5'h0, k}, 4'hF);
    wait_mode(pm);
    stop_i <= 1'b1;
    wait_mode(icscb_pkg::icscb_stop);
    check(loop_enable_o, 1'b0);
    check(ref_enable_o, k);
    s0 = sys_cnt;
    r0 = ref_cnt;
    repeat (20) @(posedge clk_i);
    check(sys_cnt - s0, 0);
    check(ref_cnt != r0, k);
    stop_i <= 1'b0;
    wake_i <= 1'b1;
    w0 = wake_cnt;
    @(posedge clk_i);
    wake_i <= 1'b0;
    wait_mode(pm);
    check(wake_cnt - w0, exp_w);
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    results();
  end

  initial begin
    arst_n_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_byteenable_i = 4'hF;
    avs_writedata_i = 32'h0;
    stop_i = 1'b0;
    wake_i = 1'b0;
    seed_v = $urandom(32'h5a3d);
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    check(mode_o, icscb_pkg::icscb_eng);
    check(source_status_o, 1'b0);
    check(loop_factor_o, `ICSCB_LOOP_MULT);
    bus_rd(`ICSCB_OFS_CTRL1, 8'h00, `ICSCB_RESP_OK);
    bus_rd(`ICSCB_OFS_CTRL2, 8'h40, `ICSCB_RESP_OK);
    bus_wr(4'h2, 8'hFF, 4'hF);
    bus_rd(4'h2, 8'h00, `ICSCB_RESP_ERR);
    coarse = $urandom;
    bus_wr(`ICSCB_OFS_TRIM, coarse, 4'hF);
    repeat (20) @(posedge clk_i);
    bus_wr(`ICSCB_OFS_STAT, 8'h05, 4'hF);
    bus_wr(`ICSCB_OFS_TRIM, ~coarse, 4'hE);
    bus_rd(`ICSCB_OFS_TRIM, coarse, `ICSCB_RESP_OK);
    bus_rd(`ICSCB_OFS_STAT, 8'h01, `ICSCB_RESP_OK);
    check(trim_o, {coarse, 1'b1});
    for (int d = 0; d < 4; d++) begin
      bus_wr(`ICSCB_OFS_CTRL2, {d[1:0], 6'h00}, 4'hF);
      measure(d);
    end
    bus_wr(`ICSCB_OFS_CTRL1, 8'h40, 4'hF);
    check(source_status_o, 1'b0);
    cur_sel = 1'b1;
    wait_mode(icscb_pkg::icscb_byp);
    repeat (20) @(posedge clk_i);
    check(source_status_o, 1'b1);
    check(loop_enable_o, 1'b1);
    bus_rd(`ICSCB_OFS_STAT, 8'h05, `ICSCB_RESP_OK);
    for (int d = 0; d < 4; d++) begin
      bus_wr(`ICSCB_OFS_CTRL2, {d[1:0], 6'h00}, 4'hF);
      measure(d);
    end
    bus_wr(`ICSCB_OFS_CTRL2, 8'h48, 4'hF);
    wait_mode(icscb_pkg::icscb_blp);
    check(loop_enable_o, 1'b0);
    bus_rd(`ICSCB_OFS_CTRL2, 8'h48, `ICSCB_RESP_OK);
    stop_run(1'b0, icscb_pkg::icscb_blp, IR_CYC);
    bus_wr(`ICSCB_OFS_CTRL2, 8'h40, 4'hF);
    repeat (20) @(posedge clk_i);
    stop_run(1'b1, icscb_pkg::icscb_byp, 0);
    cur_sel = 1'b0;
    stop_run(1'b1, icscb_pkg::icscb_eng, FLL_CYC);
    repeat (20) @(posedge clk_i);
    check(source_status_o, 1'b0);
    bus_wr(`ICSCB_OFS_CTRL2, 8'h88, 4'hF);
    bus_wr(`ICSCB_OFS_CTRL1, 8'h41, 4'hF);
    wait_mode(icscb_pkg::icscb_blp);
    stop_i <= 1'b1;
    wait_mode(icscb_pkg::icscb_stop);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    stop_i <= 1'b0;
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    check(mode_o, icscb_pkg::icscb_eng);
    check(trim_o, {coarse, 1'b1});
    bus_rd(`ICSCB_OFS_CTRL1, 8'h00, `ICSCB_RESP_OK);
    bus_rd(`ICSCB_OFS_CTRL2, 8'h40, `ICSCB_RESP_OK);
    bus_rd(`ICSCB_OFS_TRIM, coarse, `ICSCB_RESP_OK);
    bus_rd(`ICSCB_OFS_STAT, 8'h01, `ICSCB_RESP_OK);
    repeat (3) @(posedge clk_i);
    check(exp_q.size(), 0);
    results();
  end
endmodule
